/* design/run_ref_regs.svh */
// Register offsets, field positions, reset values and ranges for the run and
// speed reference source selection block.
// Assumes inclusion by bare name from design files only.
`ifndef RUN_REF_REGS_SVH
`define RUN_REF_REGS_SVH

// ------------------------------------------------------------------
// Parameter register numbers
// ------------------------------------------------------------------
`define ADDR_SPEED_REFERENCE_SOURCE 16'h0180
`define ADDR_RUN_COMMAND_SOURCE 16'h0181
`define ADDR_ANALOG_TERMINAL_FUNCTION 16'h0182
`define ADDR_CONTACTOR_CHECK 16'h0183
`define ADDR_RUN_STATUS 16'h0184
`define ADDR_SPEED_PRIORITY_MODE 16'h02a7
`define ADDR_PRESET_BASE 16'h0280
`define ADDR_PRESET_LAST 16'h0287

// ------------------------------------------------------------------
// Reset values and legal ranges
// ------------------------------------------------------------------
`define RST_SPEED_REFERENCE_SOURCE 2'h0
`define RST_RUN_COMMAND_SOURCE 2'h1
`define RST_SPEED_PRIORITY_MODE 2'h0
`define RST_ANALOG_TERMINAL_FUNCTION 16'h0000
`define RST_CONTACTOR_CHECK 1'h0
`define RST_PRESET 16'h0000
`define MAX_SOURCE_VALUE 16'h0003
`define MAX_PRIORITY_VALUE 16'h0002

// ------------------------------------------------------------------
// Status word fields
// ------------------------------------------------------------------
`define STAT_RUNNING 0
`define STAT_UP 1
`define STAT_DOWN 2
`define STAT_BLOCKED 3
`define STAT_BASE_BLOCK 4
`define STAT_CONTACTOR 5
`define STAT_SPEED_SEL 6
`define STAT_STEP_LO 8
`define STAT_STEP_HI 10

// ------------------------------------------------------------------
// Pin bundle layout after synchronisation
// ------------------------------------------------------------------
`define PIN_COUNT 12
`define PIN_FWD 0
`define PIN_REV 1
`define PIN_SPEED_SEL 2
`define PIN_BASE_BLOCK 3
`define PIN_CONTACTOR 4
`define PIN_STEP_LO 5
`define PIN_STEP_HI 7
`define PIN_KEY_RUN 8
`define PIN_KEY_STOP 9
`define PIN_KEY_DIR 10
`define PIN_ANALOG_OPT 11

`endif

/* design/run_ref_pkg.sv */
// Types shared by the run and speed reference source selection block.
// Assumes nothing of its surroundings.
package run_ref_pkg;

   typedef enum logic [1:0] {
      ST_STOPPED,
      ST_RUN_UP,
      ST_RUN_DOWN
   } run_state_t;

   typedef enum logic [1:0] {
      SRC_KEYPAD,
      SRC_TERMINAL,
      SRC_COMM,
      SRC_OPTION
   } source_t;

endpackage

/* design/pin_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/100ps

module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Pins and synchronised levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // First stage is read only by the second stage
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

/* design/preset_store.sv */
// Eight stored preset speeds, one write port and two read ports.
// Assumes the caller has already decoded the write and gives an index.
`timescale 1ns/100ps
`include "run_ref_regs.svh"

module preset_store (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Write port
   input wire logic wr_en_in,
   input wire logic [2:0] wr_idx_in,
   input wire logic [15:0] wr_data_in,
   // Read ports
   input wire logic [2:0] step_idx_in,
   output logic [15:0] step_speed_out,
   input wire logic [2:0] rd_idx_in,
   output logic [15:0] rd_data_out
);

   logic [15:0] preset_q [8];

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < 8; i++) begin
            preset_q[i] <= `RST_PRESET;
         end
      end else if (wr_en_in) begin
         preset_q[wr_idx_in] <= wr_data_in;
      end
   end

   assign step_speed_out = preset_q[step_idx_in];
   assign rd_data_out = preset_q[rd_idx_in];

endmodule

/* design/run_ref_select.sv */
// Run command qualification and speed reference source selection for a
// lift drive: start permit, stop conditions, source routing, parameters.
// Assumes a parameter access port on the core clock, asynchronous control
// pins, and serial, option and analog data already on the core clock.
`timescale 1ns/100ps
`include "run_ref_regs.svh"

// Overview of operation
// - No start in either direction unless speed selection is asserted.
// - No start while the base block inhibit is active.
// - With contactor checking enabled, start only while contactor reads closed.
// - Forward command runs up, reverse runs down, start follows the command.
// - Stop whenever the active run command is withdrawn.
// - Stop whenever speed selection is withdrawn, even with a run command.
// - Run source accepts 0 to 3, resets to 1.
// - Run source 1 takes commands from the two run terminals.
// - Run source 0 takes commands from keypad run, stop, direction keys.
// - Run source 2 takes commands written over the serial link.
// - Run source 3 takes commands from the option board.
// - Reference source accepts 0 to 3, resets to 0.
// - Reference source 0 picks a preset speed by the contact inputs.
// - Analog reference only with source 1, priority mode 0, function 0.
// - A fitted analog option board channel one replaces the analog terminal.
// - In multi-step mode 0 the analog reference serves as step one.
// - Reference source 2 takes speed written over the serial link.
// - Reference source 3 takes speed from the option board.
// - Binary multi-step selects one of eight presets, runs while commanded.
module run_ref_select (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Control terminals (asynchronous)
   input wire logic forward_run_terminal_in,
   input wire logic reverse_run_terminal_in,
   input wire logic speed_select_in,
   input wire logic base_block_in,
   input wire logic contactor_closed_in,
   input wire logic [2:0] step_select_in,
   // Keypad keys and option detect (asynchronous)
   input wire logic key_run_in,
   input wire logic key_stop_in,
   input wire logic key_dir_in,
   input wire logic analog_option_fitted_in,
   // Serial link and option board commands (core clock)
   input wire logic comm_forward_in,
   input wire logic comm_reverse_in,
   input wire logic [15:0] comm_speed_in,
   input wire logic option_forward_in,
   input wire logic option_reverse_in,
   input wire logic [15:0] option_speed_in,
   // Converted analog references (core clock)
   input wire logic [15:0] analog_speed_input_in,
   input wire logic [15:0] analog_option_ch1_in,
   // Parameter access port
   input wire logic param_wr_in,
   input wire logic param_rd_in,
   input wire logic [15:0] param_addr_in,
   input wire logic [15:0] param_wdata_in,
   output logic [15:0] param_rdata_out,
   output logic param_valid_out,
   output logic param_err_out,
   // Drive outputs
   output logic run_up_out,
   output logic run_down_out,
   output logic running_out,
   output logic start_blocked_out,
   output logic [15:0] speed_ref_out
);

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   function automatic logic addr_is_preset(input logic [15:0] addr);
      addr_is_preset = (addr >= `ADDR_PRESET_BASE) && (addr <= `ADDR_PRESET_LAST);
   endfunction

   function automatic logic [2:0] preset_index(input logic [15:0] addr);
      logic [15:0] diff;
      diff = addr - `ADDR_PRESET_BASE;
      preset_index = diff[2:0];
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------------
   logic [`PIN_COUNT-1:0] pins_raw;
   logic [`PIN_COUNT-1:0] pins_s;

   assign pins_raw = {analog_option_fitted_in, key_dir_in, key_stop_in, key_run_in,
                      step_select_in, contactor_closed_in, base_block_in,
                      speed_select_in, reverse_run_terminal_in, forward_run_terminal_in};

   pin_sync #(
      .WIDTH(`PIN_COUNT)
   ) u_pin_sync (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   logic term_fwd;
   logic term_rev;
   logic speed_sel;
   logic base_block;
   logic contactor_closed;
   logic [2:0] step_sel;
   logic analog_opt;

   assign term_fwd = pins_s[`PIN_FWD];
   assign term_rev = pins_s[`PIN_REV];
   assign speed_sel = pins_s[`PIN_SPEED_SEL];
   assign base_block = pins_s[`PIN_BASE_BLOCK];
   assign contactor_closed = pins_s[`PIN_CONTACTOR];
   assign step_sel = pins_s[`PIN_STEP_HI:`PIN_STEP_LO];
   assign analog_opt = pins_s[`PIN_ANALOG_OPT];

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   run_ref_pkg::source_t run_src_q;
   run_ref_pkg::source_t ref_src_q;
   logic [1:0] priority_mode_q;
   logic [15:0] analog_func_q;
   logic contactor_check_q;
   run_ref_pkg::run_state_t state_q;
   run_ref_pkg::run_state_t state_d;

   logic wr_ref_src;
   logic wr_run_src;
   logic wr_prio;
   logic wr_func;
   logic wr_check;
   logic wr_preset;
   logic src_value_ok;
   logic drive_stopped;

   assign drive_stopped = (state_q == run_ref_pkg::ST_STOPPED);
   assign src_value_ok = (param_wdata_in <= `MAX_SOURCE_VALUE);

   // Source writes need a legal value and a stopped drive
   assign wr_ref_src = param_wr_in && (param_addr_in == `ADDR_SPEED_REFERENCE_SOURCE)
                       && src_value_ok && drive_stopped;
   assign wr_run_src = param_wr_in && (param_addr_in == `ADDR_RUN_COMMAND_SOURCE)
                       && src_value_ok && drive_stopped;
   assign wr_prio = param_wr_in && (param_addr_in == `ADDR_SPEED_PRIORITY_MODE)
                    && (param_wdata_in <= `MAX_PRIORITY_VALUE);
   assign wr_func = param_wr_in && (param_addr_in == `ADDR_ANALOG_TERMINAL_FUNCTION);
   assign wr_check = param_wr_in && (param_addr_in == `ADDR_CONTACTOR_CHECK);
   assign wr_preset = param_wr_in && addr_is_preset(param_addr_in);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         run_src_q <= run_ref_pkg::source_t'(`RST_RUN_COMMAND_SOURCE);
         ref_src_q <= run_ref_pkg::source_t'(`RST_SPEED_REFERENCE_SOURCE);
      end else begin
         if (wr_run_src) begin
            run_src_q <= run_ref_pkg::source_t'(param_wdata_in[1:0]);
         end
         if (wr_ref_src) begin
            ref_src_q <= run_ref_pkg::source_t'(param_wdata_in[1:0]);
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         priority_mode_q <= `RST_SPEED_PRIORITY_MODE;
         analog_func_q <= `RST_ANALOG_TERMINAL_FUNCTION;
         contactor_check_q <= `RST_CONTACTOR_CHECK;
      end else begin
         if (wr_prio) begin
            priority_mode_q <= param_wdata_in[1:0];
         end
         if (wr_func) begin
            analog_func_q <= param_wdata_in;
         end
         if (wr_check) begin
            contactor_check_q <= param_wdata_in[0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Keypad command latch
   // ------------------------------------------------------------------
   // Keys act on their rising edge; the direction key only flips while
   // stopped so a test run never reverses under load.
   logic keys_prev_q [3];
   logic key_run_edge;
   logic key_stop_edge;
   logic key_dir_edge;
   logic key_run_q;
   logic key_down_q;

   assign key_run_edge = pins_s[`PIN_KEY_RUN] && !keys_prev_q[0];
   assign key_stop_edge = pins_s[`PIN_KEY_STOP] && !keys_prev_q[1];
   assign key_dir_edge = pins_s[`PIN_KEY_DIR] && !keys_prev_q[2];

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         keys_prev_q[0] <= 1'b0;
         keys_prev_q[1] <= 1'b0;
         keys_prev_q[2] <= 1'b0;
      end else begin
         keys_prev_q[0] <= pins_s[`PIN_KEY_RUN];
         keys_prev_q[1] <= pins_s[`PIN_KEY_STOP];
         keys_prev_q[2] <= pins_s[`PIN_KEY_DIR];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         key_run_q <= 1'b0;
         key_down_q <= 1'b0;
      end else if (run_src_q != run_ref_pkg::SRC_KEYPAD) begin
         key_run_q <= 1'b0;
      end else begin
         // Stop key wins over a run key in the same cycle
         if (key_stop_edge) begin
            key_run_q <= 1'b0;
         end else if (key_run_edge) begin
            key_run_q <= 1'b1;
         end
         if (key_dir_edge && drive_stopped) begin
            key_down_q <= !key_down_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // Run command source routing
   // ------------------------------------------------------------------
   logic cmd_fwd;
   logic cmd_rev;

   always_comb begin
      case (run_src_q)
         run_ref_pkg::SRC_KEYPAD: begin
            cmd_fwd = key_run_q && !key_down_q;
            cmd_rev = key_run_q && key_down_q;
         end
         run_ref_pkg::SRC_TERMINAL: begin
            cmd_fwd = term_fwd;
            cmd_rev = term_rev;
         end
         run_ref_pkg::SRC_COMM: begin
            cmd_fwd = comm_forward_in;
            cmd_rev = comm_reverse_in;
         end
         run_ref_pkg::SRC_OPTION: begin
            cmd_fwd = option_forward_in;
            cmd_rev = option_reverse_in;
         end
         default: begin
            cmd_fwd = 1'b0;
            cmd_rev = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Start permit and run sequence
   // ------------------------------------------------------------------
   logic start_ok;
   logic one_cmd;
   logic want_start;

   // Both commands at once is ambiguous; it starts nothing
   assign one_cmd = cmd_fwd ^ cmd_rev;
   assign start_ok = speed_sel
                     && !base_block
                     && (!contactor_check_q || contactor_closed);
   assign want_start = one_cmd && start_ok;

   always_comb begin
      state_d = state_q;
      case (state_q)
         run_ref_pkg::ST_STOPPED: begin
            if (want_start && cmd_fwd) begin
               state_d = run_ref_pkg::ST_RUN_UP;
            end else if (want_start && cmd_rev) begin
               state_d = run_ref_pkg::ST_RUN_DOWN;
            end
         end
         run_ref_pkg::ST_RUN_UP: begin
            // Base block cuts the output, so the sequence drops with it
            if (!cmd_fwd || !speed_sel || base_block) begin
               state_d = run_ref_pkg::ST_STOPPED;
            end
         end
         run_ref_pkg::ST_RUN_DOWN: begin
            if (!cmd_rev || !speed_sel || base_block) begin
               state_d = run_ref_pkg::ST_STOPPED;
            end
         end
         default: begin
            state_d = run_ref_pkg::ST_STOPPED;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_q <= run_ref_pkg::ST_STOPPED;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         run_up_out <= 1'b0;
         run_down_out <= 1'b0;
         running_out <= 1'b0;
         start_blocked_out <= 1'b0;
      end else begin
         run_up_out <= (state_d == run_ref_pkg::ST_RUN_UP);
         run_down_out <= (state_d == run_ref_pkg::ST_RUN_DOWN);
         running_out <= (state_d != run_ref_pkg::ST_STOPPED);
         start_blocked_out <= drive_stopped && (cmd_fwd || cmd_rev) && !want_start;
      end
   end

   // ------------------------------------------------------------------
   // Speed reference routing
   // ------------------------------------------------------------------
   logic [15:0] preset_speed;
   logic [15:0] preset_rd;
   logic [15:0] analog_ref;
   logic analog_allowed;
   logic [15:0] speed_d;

   preset_store u_preset_store (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .wr_en_in(wr_preset),
      .wr_idx_in(preset_index(param_addr_in)),
      .wr_data_in(param_wdata_in),
      .step_idx_in(step_sel),
      .step_speed_out(preset_speed),
      .rd_idx_in(preset_index(param_addr_in)),
      .rd_data_out(preset_rd)
   );

   assign analog_ref = analog_opt ? analog_option_ch1_in : analog_speed_input_in;
   assign analog_allowed = (ref_src_q == run_ref_pkg::SRC_TERMINAL)
                           && (priority_mode_q == 2'h0)
                           && (analog_func_q == 16'h0000);

   always_comb begin
      case (ref_src_q)
         run_ref_pkg::SRC_KEYPAD: begin
            speed_d = preset_speed;
         end
         run_ref_pkg::SRC_TERMINAL: begin
            // Analog only stands in for step one; other steps stay presets
            if (analog_allowed && (step_sel == 3'h0)) begin
               speed_d = analog_ref;
            end else begin
               speed_d = preset_speed;
            end
         end
         run_ref_pkg::SRC_COMM: begin
            speed_d = comm_speed_in;
         end
         run_ref_pkg::SRC_OPTION: begin
            speed_d = option_speed_in;
         end
         default: begin
            speed_d = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         speed_ref_out <= 16'h0000;
      end else begin
         speed_ref_out <= speed_d;
      end
   end

   // ------------------------------------------------------------------
   // Parameter read and error answer
   // ------------------------------------------------------------------
   logic [15:0] status_word;
   logic [15:0] rd_d;
   logic mapped;
   logic wr_refused;

   always_comb begin
      status_word = 16'h0000;
      status_word[`STAT_RUNNING] = !drive_stopped;
      status_word[`STAT_UP] = (state_q == run_ref_pkg::ST_RUN_UP);
      status_word[`STAT_DOWN] = (state_q == run_ref_pkg::ST_RUN_DOWN);
      status_word[`STAT_BLOCKED] = start_blocked_out;
      status_word[`STAT_BASE_BLOCK] = base_block;
      status_word[`STAT_CONTACTOR] = contactor_closed;
      status_word[`STAT_SPEED_SEL] = speed_sel;
      status_word[`STAT_STEP_HI:`STAT_STEP_LO] = step_sel;
   end

   always_comb begin
      mapped = 1'b1;
      rd_d = 16'h0000;
      if (addr_is_preset(param_addr_in)) begin
         rd_d = preset_rd;
      end else begin
         case (param_addr_in)
            `ADDR_SPEED_REFERENCE_SOURCE: rd_d = {14'h0000, ref_src_q};
            `ADDR_RUN_COMMAND_SOURCE: rd_d = {14'h0000, run_src_q};
            `ADDR_SPEED_PRIORITY_MODE: rd_d = {14'h0000, priority_mode_q};
            `ADDR_ANALOG_TERMINAL_FUNCTION: rd_d = analog_func_q;
            `ADDR_CONTACTOR_CHECK: rd_d = {15'h0000, contactor_check_q};
            `ADDR_RUN_STATUS: rd_d = status_word;
            default: mapped = 1'b0;
         endcase
      end
   end

   // Any write that stored nothing is reported, including the status word
   assign wr_refused = param_wr_in && !(wr_ref_src || wr_run_src || wr_prio
                                        || wr_func || wr_check || wr_preset);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         param_rdata_out <= 16'h0000;
         param_valid_out <= 1'b0;
         param_err_out <= 1'b0;
      end else begin
         param_valid_out <= param_rd_in && !param_wr_in && mapped;
         param_err_out <= wr_refused || (param_rd_in && !param_wr_in && !mapped);
         if (param_rd_in && !param_wr_in && mapped) begin
            param_rdata_out <= rd_d;
         end
      end
   end

endmodule

/* test/run_ref_assertions.sv */
// Checker for the run and reference selection block, bound to its ports.
// Assumes pins are sampled three edges before the run outputs answer.
`timescale 1ns/100ps
module run_ref_assertions (
   input wire logic core_clk_in, rst_in, speed_select_in, base_block_in,
   input wire logic param_wr_in,
   input wire logic [15:0] param_addr_in, param_wdata_in,
   input wire logic param_err_out, run_up_out, run_down_out, running_out,
   input wire logic start_blocked_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // ------------------------------------------------------------------
   // Run outputs
   // ------------------------------------------------------------------
   property p_one_dir; !(run_up_out && run_down_out); endproperty
   a_one_dir: assert property (p_one_dir) else $error("both directions");
   property p_running; running_out == (run_up_out || run_down_out); endproperty
   a_running: assert property (p_running) else $error("running mismatch");
   property p_sel_start; $rose(running_out) |-> $past(speed_select_in, 3); endproperty
   a_sel_start: assert property (p_sel_start) else $error("start w/o select");
   property p_blk; start_blocked_out |-> !running_out; endproperty
   a_blk: assert property (p_blk) else $error("blocked while running");
   property p_sel_stop; $past(!speed_select_in, 3) |-> !running_out; endproperty
   a_sel_stop: assert property (p_sel_stop) else $error("run w/o select");
   property p_bb; $past(base_block_in, 3) |-> !running_out; endproperty
   a_bb: assert property (p_bb) else $error("run under inhibit");
   // ------------------------------------------------------------------
   // Source settings
   // ------------------------------------------------------------------
   property p_run_src;
      $past(param_wr_in && param_addr_in == 16'h0181 && param_wdata_in > 16'h0003)
         |-> param_err_out;
   endproperty
   a_run_src: assert property (p_run_src) else $error("run source range");
   property p_ref_src;
      $past(param_wr_in && param_addr_in == 16'h0180 && param_wdata_in > 16'h0003)
         |-> param_err_out;
   endproperty
   a_ref_src: assert property (p_ref_src) else $error("ref source range");
   property p_lock;
      running_out && param_wr_in && param_addr_in == 16'h0181 |=> param_err_out;
   endproperty
   a_lock: assert property (p_lock) else $error("write while running");
endmodule
bind run_ref_select run_ref_assertions i_chk (.*);

/* test/lift_ctl_model.sv */
// Lift controller model driving the direction and speed selection terminals.
// Assumes the bench states its intent on the core clock.
`timescale 1ns/100ps
module lift_ctl_model (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic want_up_in,
   input wire logic want_down_in,
   input wire logic want_sel_in,
   output logic fwd_out,
   output logic rev_out,
   output logic sel_out
);
   // A controller never asks for both directions at once
   always_ff @(posedge core_clk_in) begin
      fwd_out <= !rst_in && want_up_in && !want_down_in;
      rev_out <= !rst_in && want_down_in && !want_up_in;
      sel_out <= !rst_in && want_sel_in;
   end
endmodule

/* test/testbench.sv */
// Self-checking bench for the run and reference selection block.
// Assumes the lift controller model drives the run and select terminals.
`timescale 1ns/100ps
module testbench;
   logic core_clk_in = 0, rst_in = 1, base_block_in = 0, contactor_closed_in = 0;
   logic key_run_in = 0, key_stop_in = 0, key_dir_in = 0, analog_option_fitted_in = 0;
   logic comm_forward_in = 0, comm_reverse_in = 0, option_forward_in = 0;
   logic option_reverse_in = 0, param_wr_in = 0, param_rd_in = 0;
   logic want_up = 0, want_down = 0, want_sel = 0;
   logic forward_run_terminal_in, reverse_run_terminal_in, speed_select_in;
   logic [2:0] step_select_in = 0;
   logic [15:0] comm_speed_in = 16'h1234, option_speed_in = 16'h5678;
   logic [15:0] analog_speed_input_in = 16'h0abc, analog_option_ch1_in = 16'h0def;
   logic [15:0] param_addr_in = 0, param_wdata_in = 0, param_rdata_out, speed_ref_out;
   logic param_valid_out, param_err_out, run_up_out, run_down_out, running_out, start_blocked_out;
   int err_total = 0, n_tests = 0;
   always #2 core_clk_in = ~core_clk_in;
   run_ref_select i_dut (.*);
   lift_ctl_model i_ctl (.core_clk_in(core_clk_in), .rst_in(rst_in), .want_up_in(want_up),
      .want_down_in(want_down), .want_sel_in(want_sel), .fwd_out(forward_run_terminal_in),
      .rev_out(reverse_run_terminal_in), .sel_out(speed_select_in));
   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", n, e, s);
         err_total++;
      end
   endtask
   task settle;
      repeat (6) @(posedge core_clk_in);
      #1;
   endtask
   task wr(input logic [15:0] a, input logic [15:0] d, input logic e);
      @(posedge core_clk_in);
      param_wr_in <= 1; param_addr_in <= a; param_wdata_in <= d;
      @(posedge core_clk_in);
      param_wr_in <= 0;
      #1 chk("param_err", param_err_out, e);
   endtask
   task rd(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      param_rd_in <= 1; param_addr_in <= a;
      @(posedge core_clk_in);
      param_rd_in <= 0;
      #1 chk("param_valid", param_valid_out, 1);
      chk("param_rdata", param_rdata_out, d);
   endtask
   task stop_test;
      $display("tests %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task t_regs;
      rd(16'h0180, 16'h0000);
      rd(16'h0181, 16'h0001);
      wr(16'h0181, 16'h0004, 1);
      wr(16'h0180, 16'h0005, 1);
      wr(16'h0999, 16'h0000, 1);
      rd(16'h0181, 16'h0001);
      $display("t_regs done");
   endtask
   task t_term;
      @(posedge core_clk_in); want_up <= 1;
      settle; chk("running", running_out, 0);
      chk("blocked", start_blocked_out, 1);
      @(posedge core_clk_in); want_sel <= 1;
      settle; chk("run_up", run_up_out, 1);
      wr(16'h0181, 16'h0002, 1);
      @(posedge core_clk_in); want_sel <= 0;
      settle; chk("running", running_out, 0);
      @(posedge core_clk_in); want_sel <= 1; base_block_in <= 1;
      settle; chk("running", running_out, 0);
      @(posedge core_clk_in); base_block_in <= 0;
      settle; chk("run_up", run_up_out, 1);
      @(posedge core_clk_in); want_up <= 0;
      settle; chk("running", running_out, 0);
      @(posedge core_clk_in); want_down <= 1;
      settle; chk("run_down", run_down_out, 1);
      @(posedge core_clk_in); want_down <= 0;
      settle; chk("running", running_out, 0);
      $display("t_term done");
   endtask
   task t_src;
      wr(16'h0181, 16'h0002, 0);
      @(posedge core_clk_in); comm_forward_in <= 1;
      settle; chk("run_up", run_up_out, 1);
      @(posedge core_clk_in); comm_forward_in <= 0;
      settle; wr(16'h0181, 16'h0003, 0);
      @(posedge core_clk_in); option_reverse_in <= 1;
      settle; chk("run_down", run_down_out, 1);
      @(posedge core_clk_in); option_reverse_in <= 0;
      settle; wr(16'h0181, 16'h0001, 0);
      wr(16'h0183, 16'h0001, 0);
      @(posedge core_clk_in); want_up <= 1;
      settle; chk("running", running_out, 0);
      @(posedge core_clk_in); contactor_closed_in <= 1;
      settle; chk("running", running_out, 1);
      @(posedge core_clk_in); want_up <= 0;
      settle; wr(16'h0181, 16'h0000, 0);
      @(posedge core_clk_in); key_run_in <= 1;
      settle; chk("run_up", run_up_out, 1);
      @(posedge core_clk_in); key_run_in <= 0; key_stop_in <= 1;
      settle; chk("running", running_out, 0);
      $display("t_src done");
   endtask
   task t_ref;
      wr(16'h0283, 16'h0333, 0);
      @(posedge core_clk_in); step_select_in <= 3'h3;
      settle; chk("speed_ref", speed_ref_out, 16'h0333);
      wr(16'h0180, 16'h0002, 0); settle; chk("speed_ref", speed_ref_out, 16'h1234);
      wr(16'h0180, 16'h0003, 0); settle; chk("speed_ref", speed_ref_out, 16'h5678);
      wr(16'h0180, 16'h0001, 0); settle; chk("speed_ref", speed_ref_out, 16'h0333);
      @(posedge core_clk_in); step_select_in <= 3'h0;
      settle; chk("speed_ref", speed_ref_out, 16'h0abc);
      @(posedge core_clk_in); analog_option_fitted_in <= 1;
      settle; chk("speed_ref", speed_ref_out, 16'h0def);
      $display("t_ref done");
   endtask
   initial begin
      repeat (2) @(posedge core_clk_in);
      rst_in <= 0;
      t_regs; t_term; t_src; t_ref;
      stop_test;
   end
   initial begin
      #40000 err_total++;
      stop_test;
   end
endmodule
